// *** logic/ats_trigger_select.sv ***
// Trigger-source selection and start request generation for sequencers 0 and 1
`timescale 1ns/1ps
`default_nettype none
module ats_trigger_select
	import ats_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Select word write port
	input  wire logic                        sel_write,
	input  wire logic [2*SEL_W-1:0]          sel_wdata,
	output logic      [2*SEL_W-1:0]          sel_rdata,
	// Processor-initiated sample request, one bit per sequencer
	input  wire logic [SEQ_COUNT-1:0]        proc_initiate,
	// Hardware sources
	input  var  ats_sources_t                sources,
	// Sequencer handshake
	input  wire logic [SEQ_COUNT-1:0]        run_done,
	output logic      [SEQ_COUNT-1:0]        start_request
);

	////////////////////////////////////////////////////////////////////////
	// Source decode

	// Level of the chosen hardware source; reserved codes give no event
	// Reserved codes and the processor code fall to the default branch
	function automatic logic source_level(input logic [SEL_W-1:0] sel, input ats_sources_t src);
		case (sel)
			SEL_COMP0:   source_level = src.comp[0];
			SEL_COMP1:   source_level = src.comp[1];
			SEL_COMP2:   source_level = src.comp[2];
			SEL_EXT_PIN: source_level = src.ext_pin;
			// The timer only raises this line while its own output enable is set
			SEL_TIMER:   source_level = src.timer_trig;
			default:     source_level = 1'b0;
		endcase
	endfunction

	// Select field of one sequencer
	function automatic logic [SEL_W-1:0] sel_field(input logic [2*SEL_W-1:0] word, input int idx);
		case (idx)
			0:       sel_field = word[SEQ0_SEL_LSB +: SEL_W];
			1:       sel_field = word[SEQ1_SEL_LSB +: SEL_W];
			default: sel_field = SEL_RESET;
		endcase
	endfunction

	// Continuous mode needs no event and re-arms itself after each run
	function automatic logic is_continuous(input logic [SEL_W-1:0] sel);
		is_continuous = (sel == SEL_ALWAYS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Select register

	// Written whole; a reserved code is stored as is
	// and simply gives no hardware event
	logic [2*SEL_W-1:0] sel_reg;
	logic [2*SEL_W-1:0] sel_next;

	always_comb
	begin
		sel_next = sel_reg;
		if (sel_write)
		begin
			sel_next = sel_wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sel_reg <= {SEL_RESET, SEL_RESET};
		end
		else
		begin
			sel_reg <= sel_next;
		end
	end

	assign sel_rdata = sel_reg;

	////////////////////////////////////////////////////////////////////////
	// Source history

	// One history bit per source, so a change of select cannot fake an edge:
	// a source that is already high when selected gives no start
	ats_sources_t src_last_reg;
	ats_sources_t src_last_next;

	always_comb
	begin
		src_last_next = sources;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			src_last_reg <= '0;
		end
		else
		begin
			src_last_reg <= src_last_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-sequencer start logic

	// Each sequencer runs its own small state machine; the two share
	// only the select word, the live sources and the source history, so they may start in the same cycle.
	// A start during a run is not queued: the far side must drop and raise
	// the source again after the run ends if it needs a second start.
	genvar g;
	generate
		for (g = 0; g < SEQ_COUNT; g++)
		begin : g_seq
			logic [SEL_W-1:0] sel;
			logic             level_now;
			logic             level_last;
			logic             rise;
			logic             continuous;
			logic             start_reg;
			logic             start_next;
			ats_state_t       state_reg;
			ats_state_t       state_next;

			assign sel = sel_field(sel_reg, g);
			assign continuous = is_continuous(sel);

			// Rising edge of the selected source only
			always_comb
			begin
				level_now  = source_level(sel, sources);
				level_last = source_level(sel, src_last_reg);
				rise       = level_now && !level_last;
			end

			////////////////////////////////////////////////////////////////
			// Run state machine

			always_comb
			begin
				start_next = 1'b0;
				state_next = state_reg;
				case (state_reg)
					ATS_IDLE:
					begin
						// Processor request works whatever the select holds
						if (proc_initiate[g])
						begin
							start_next = 1'b1;
						end
						else if (continuous)
						begin
							start_next = 1'b1;
						end
						else if (rise)
						begin
							start_next = 1'b1;
						end
						if (start_next)
						begin
							state_next = ATS_RUNNING;
						end
					end
					ATS_RUNNING:
					begin
						// Edges during a run are dropped; no queueing of events
						if (run_done[g])
						begin
							state_next = ATS_IDLE;
							if (continuous)
							begin
								start_next = 1'b1;
								state_next = ATS_RUNNING;
							end
						end
					end
					// Unused state encoding falls back to idle
					default:
					begin
						state_next = ATS_IDLE;
					end
				endcase
			end

			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					start_reg <= 1'b0;
					state_reg <= ATS_IDLE;
				end
				else
				begin
					start_reg <= start_next;
					state_reg <= state_next;
				end
			end

			// Straight from the register, one clean pulse per start
			assign start_request[g] = start_reg;
		end
	endgenerate

endmodule
`default_nettype wire

// *** logic/ats_pkg.sv ***
// Package for the converter trigger-source selection block
`default_nettype none
package ats_pkg;
	localparam int SEQ_COUNT = 2;
	localparam int SEL_W = 4;
	// Field positions in the packed select word
	localparam int SEQ0_SEL_LSB = 0;
	localparam int SEQ1_SEL_LSB = 4;
	localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
	// Select encodings
	localparam logic [SEL_W-1:0] SEL_PROCESSOR = 4'h0;
	localparam logic [SEL_W-1:0] SEL_COMP0 = 4'h1;
	localparam logic [SEL_W-1:0] SEL_COMP1 = 4'h2;
	localparam logic [SEL_W-1:0] SEL_COMP2 = 4'h3;
	localparam logic [SEL_W-1:0] SEL_EXT_PIN = 4'h4;
	localparam logic [SEL_W-1:0] SEL_TIMER = 4'h5;
	localparam logic [SEL_W-1:0] SEL_ALWAYS = 4'hF;

	// Hardware event sources, sampled each clock
	typedef struct packed {
		logic       timer_trig;
		logic       ext_pin;
		logic [2:0] comp;
	} ats_sources_t;

	typedef enum logic [1:0] {
		ATS_IDLE,
		ATS_RUNNING
	} ats_state_t;
endpackage
`default_nettype wire

// *** testbench/ats_far_side.sv ***
// Far-side model: comparators, external trigger pin and gated timer trigger
`timescale 1ns/1ps
`default_nettype none
module ats_far_side (
	input  wire logic                  clk,
	input  wire logic [4:0]            lvl,
	input  wire logic                  te,
	output var  ats_pkg::ats_sources_t sources
);
	// Timer trigger only leaves the timer while its converter output enable is set
	always_ff @(posedge clk) sources <= lvl & {te, 4'hF};
endmodule
`default_nettype wire

// *** testbench/ats_props.sv ***
// Checker for the trigger-source selection block
`timescale 1ns/1ps
`default_nettype none
module ats_props
	import ats_pkg::*;
(
	// Watched ports
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sel_write,
	input wire logic [7:0]  sel_wdata,
	input wire logic [7:0]  sel_rdata,
	input wire logic [1:0]  proc_initiate,
	input var ats_sources_t sources,
	input wire logic [1:0]  run_done,
	input wire logic [1:0]  start_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reset_clear_a: assert property ($past(rst) |-> sel_rdata == 8'h00 && start_request == 2'h0) else $error("rst");
	sel_load_a: assert property (sel_write |=> sel_rdata == $past(sel_wdata)) else $error("load");
	sel_hold_a: assert property (!sel_write |=> $stable(sel_rdata)) else $error("hold");
	proc_only_a: assert property (sel_rdata[3:0] == 4'h0 && !proc_initiate[0] |=> !start_request[0])
		else $error("proc");
	reserved_quiet_a: assert property (sel_rdata[7:4] inside {[4'h6:4'hE]} && !proc_initiate[1] |=>
		!start_request[1]) else $error("reserved");
	comp_rise_a: assert property (start_request[0] && $past(sel_rdata[3:0]) == 4'h1 |->
		$past(proc_initiate[0]) || $past(sources.comp[0]) && !$past(sources.comp[0], 2)) else $error("comp");
	free_run_a: assert property (sel_rdata[3:0] == 4'hF && run_done[0] |=> start_request[0]) else $error("free");
	pulse_once_a: assert property (start_request[0] |=> !start_request[0]) else $error("pulse");
	cover property (start_request[0] && sel_rdata[3:0] == 4'h1);
	cover property (start_request[1] && sel_rdata[7:4] == 4'hF);
	cover property (sel_write ##1 start_request == 2'h3);
endmodule
bind ats_trigger_select ats_props u_props (.clk, .rst, .sel_write, .sel_wdata, .sel_rdata, .proc_initiate,
	.sources, .run_done, .start_request);
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the trigger-source selection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                  clk = 1'b0, rst = 1'b1, sel_write = 1'b0, te = 1'b1;
	logic [7:0]            sel_wdata = 8'h00, sel_rdata;
	logic [1:0]            proc_initiate = 2'h0, run_done = 2'h0, start_request, seen;
	logic [4:0]            lvl = 5'h00, s;
	logic [3:0]            c;
	int                    mismatches = 0, n_compared = 0;
	ats_pkg::ats_sources_t sources;
	always #5 clk = ~clk;
	ats_trigger_select uut (.clk, .rst, .sel_write, .sel_wdata, .sel_rdata, .proc_initiate, .sources,
		.run_done, .start_request);
	ats_far_side far (.clk, .lvl, .te, .sources);
	task chk(input string n, input logic [7:0] e, v);
		n_compared++;
		if (v !== e)
		begin
			$display("[ERR] %s exp %h got %h", n, e, v);
			mismatches++;
		end
	endtask
	// Sources rise with the write, so any start lands inside the four-edge window
	task run(input logic [7:0] d, input logic [3:0] rp, input logic [1:0] e);
		{sel_write, sel_wdata, run_done, proc_initiate} <= {1'b1, d, rp};
		@(posedge clk);
		{sel_write, run_done, proc_initiate} <= 5'h00;
		seen = 2'h0;
		repeat (4) @(posedge clk) seen |= start_request;
		chk("select", d, sel_rdata);
		chk("start", {6'h00, e}, {6'h00, seen});
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		chk("select", 8'h00, sel_rdata);
		rst <= 1'b0;
		// Last pass reuses the timer code with its output enable off
		for (int i = 0; i < 16; i++)
		begin
			c = i == 15 ? 4'h5 : 4'(i);
			s = c inside {[4'h1:4'h5]} ? 5'(1 << (c - 4'h1)) : 5'h1F;
			te <= i != 15;
			// For codes 1 to 5 every source but the selected one rises, for other codes none does: no start may follow
			lvl <= ~s;
			run({c, c}, 4'h0, 2'h0);
			lvl <= 5'h00;
			run(8'h00, 4'hC, 2'h0);
			lvl <= s;
			run({c, c}, 4'h0, c inside {[4'h1:4'h5]} && i != 15 ? 2'h3 : 2'h0);
			lvl <= 5'h00;
			run(8'h00, 4'hC, 2'h0);
		end
		run(8'h00, 4'h3, 2'h3);
		run(8'hFF, 4'hC, 2'h3);
		run(8'hFF, 4'hC, 2'h3);
		finish_test;
	end
endmodule
`default_nettype wire
